/* File: pkg/counter_array_cfg.svh */
`ifndef COUNTER_ARRAY_CFG_SVH
`define COUNTER_ARRAY_CFG_SVH

`define NUM_MODULES     5
`define IDX_W           3
`define ADDR_W          8
`define DATA_W          32
`define CNT_W           16
`define BYTE_W          8

// mode register bit positions
`define MODE_TOG_BIT    0
`define MODE_MAT_BIT    1
`define MODE_PWM_BIT    2
`define MODE_COMPARATOR_ENABLE_BIT   3
`define MODE_MASK       8'h0f

// address map: paddr[7] selects the status page, [6:4] module, [3:0] reg
`define PAGE_BIT        7
`define IDX_HI          6
`define IDX_LO          4
`define OFF_HI          3
`define OFF_LO          0
`define OFF_MODE        4'h0
`define OFF_LOW         4'h4
`define OFF_HIGH        4'h8
`define OFF_SPARE       4'hc
`define ADDR_PINS       8'h80

`define LOW_MAX         8'hff
`define LOW_ZERO        8'h00
`define MODE_RESET      8'h00
`define CMP_RESET       8'h00
`define PIN_RESET       1'b0
`define WORD_ZERO       32'h0000_0000

`endif

/* File: pkg/counter_array_pkg.sv */
`include "counter_array_cfg.svh"

package counter_array_pkg;

    typedef enum logic [1:0]
    {
        MODE_OFF = 2'b00,
        MODE_HSO = 2'b01,
        MODE_PWM = 2'b10
    } out_mode_t;

    typedef struct packed
    {
        logic [`BYTE_W-1:0] cmp_low;
        logic [`BYTE_W-1:0] cmp_high;
        logic [`BYTE_W-1:0] prev_low;
        logic               pin;
    } channel_state_t;

    typedef struct packed
    {
        logic [`NUM_MODULES-1:0][`BYTE_W-1:0] mode;
        logic [`DATA_W-1:0]                   rdata;
        logic                                 slverr;
    } regs_state_t;

    // pwm wins if software sets both mode families at once
    function automatic out_mode_t decode_mode(input logic [`BYTE_W-1:0] m);
        if (m[`MODE_COMPARATOR_ENABLE_BIT] && m[`MODE_PWM_BIT])
            return MODE_PWM;
        else if (m[`MODE_COMPARATOR_ENABLE_BIT] && m[`MODE_TOG_BIT] && m[`MODE_MAT_BIT])
            return MODE_HSO;
        else
            return MODE_OFF;
    endfunction

endpackage

/* File: rtl/compare_channel.sv */
`timescale 1ns/100ps
`include "counter_array_cfg.svh"

module compare_channel
    import counter_array_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire logic [`CNT_W-1:0]   counter_value,
    input  wire logic [`BYTE_W-1:0]  mode,
    input  wire logic                wr_low,
    input  wire logic                wr_high,
    input  wire logic [`BYTE_W-1:0]  wdata,
    output logic                     pin,
    output logic [`BYTE_W-1:0]       cmp_low,
    output logic [`BYTE_W-1:0]       cmp_high
);

    channel_state_t      q;
    channel_state_t      d;
    out_mode_t           mode_now;
    logic [`BYTE_W-1:0]  cl;
    logic                match;
    logic                wrap;

    assign mode_now = decode_mode(mode); // see R2 // see R7
    assign cl       = counter_value[`BYTE_W-1:0];
    assign match    = (counter_value == {q.cmp_high, q.cmp_low});
    assign wrap     = (q.prev_low == `LOW_MAX) && (cl == `LOW_ZERO);

    always_comb
    begin
        d          = q;
        d.prev_low = cl;
        case (mode_now)
            MODE_HSO:
            begin
                // level only moves on a match, never on a write
                if (match)
                    d.pin = ~q.pin; // see R1 // see R8
            end
            MODE_PWM:
            begin
                d.pin = (cl >= q.cmp_low); // see R5 // see R3
                if (wrap)
                    d.cmp_low = q.cmp_high; // see R6
            end
            default:
            begin
                d.pin = q.pin;
            end
        endcase
        // an explicit software write beats the reload in the same cycle
        if (wr_low)
            d.cmp_low = wdata; // see R4
        if (wr_high)
            d.cmp_high = wdata;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q.cmp_low  <= `CMP_RESET;
            q.cmp_high <= `CMP_RESET;
            q.prev_low <= `LOW_ZERO;
            q.pin      <= `PIN_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign pin      = q.pin;
    assign cmp_low  = q.cmp_low;
    assign cmp_high = q.cmp_high;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence hso_match_s;
        mode_now == MODE_HSO && counter_value == {cmp_high, cmp_low};
    endsequence

    sequence pwm_wrap_s;
        mode_now == MODE_PWM && cl == `LOW_MAX
        ##1 mode_now == MODE_PWM && cl == `LOW_ZERO && !wr_low;
    endsequence

    hso_toggle_a: assert property ( // see R1
        hso_match_s |=> pin != $past(pin))
        else $error("pin did not toggle on compare match");

    hso_hold_a: assert property ( // see R8
        mode_now == MODE_HSO && !(counter_value == {cmp_high, cmp_low})
        |=> $stable(pin))
        else $error("pin moved without a compare match");

    hso_gate_a: assert property ( // see R2
        mode[`MODE_COMPARATOR_ENABLE_BIT] && !mode[`MODE_PWM_BIT]
        && !(mode[`MODE_TOG_BIT] && mode[`MODE_MAT_BIT]) |=> $stable(pin))
        else $error("high speed output active without all enables");

    pwm_gate_a: assert property ( // see R7
        !mode[`MODE_COMPARATOR_ENABLE_BIT] |=> $stable(pin))
        else $error("output moved with comparator disabled");

    pwm_low_a: assert property ( // see R5
        mode_now == MODE_PWM && cl < cmp_low |=> !pin)
        else $error("pwm output not low below compare byte");

    pwm_high_a: assert property ( // see R5
        mode_now == MODE_PWM && cl >= cmp_low |=> pin)
        else $error("pwm output not high at or above compare byte");

    pwm_reload_a: assert property ( // see R6
        pwm_wrap_s |=> cmp_low == $past(cmp_high))
        else $error("low compare byte not reloaded on wrap");

    low_stable_a: assert property ( // see R4
        !wr_low && !(mode_now == MODE_PWM && wrap) |=> $stable(cmp_low))
        else $error("low compare byte changed without cause");

endmodule

/* File: rtl/counter_array_compare.sv */
`timescale 1ns/100ps
`include "counter_array_cfg.svh"

// Notes on behaviour
// R1: hso mode inverts the pin on every cycle the counter matches the pair.
// R2: hso mode needs toggle, match and comparator enables all set.
// R3: all modules take their pwm period from the one shared counter.
// R4: each module's duty comes only from its own low compare byte.
// R5: in pwm mode the pin is low below the low compare byte, else high.
// R6: in pwm mode, on a low byte wrap from ff to 00 the low compare is loaded from the high one.
// R7: pwm mode needs both the pwm enable and the comparator enable set.
// R8: in hso mode the pin holds between matches; compare writes leave it.
module counter_array_compare
    import counter_array_pkg::*;
(
    input  wire logic                     clock,
    input  wire logic                     resetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`ADDR_W-1:0]       paddr,
    input  wire logic [`DATA_W-1:0]       pwdata,
    output logic                          pready,
    output logic [`DATA_W-1:0]            prdata,
    output logic                          pslverr,
    input  wire logic [`CNT_W-1:0]        counter_value,
    output logic [`NUM_MODULES-1:0]       module_output_pin
);

    logic                                 rst_meta_q;
    logic                                 rst_n;
    regs_state_t                          q;
    regs_state_t                          d;
    logic                                 setup;
    logic                                 wr_access;
    logic [`NUM_MODULES-1:0]              wr_low;
    logic [`NUM_MODULES-1:0]              wr_high;
    logic [`NUM_MODULES-1:0][`BYTE_W-1:0] cmp_low;
    logic [`NUM_MODULES-1:0][`BYTE_W-1:0] cmp_high;

    // async assert, release through two flops
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    function automatic logic hit(input logic [`ADDR_W-1:0] a,
                                 input int unsigned        idx,
                                 input logic [3:0]         off);
        return !a[`PAGE_BIT]
            && (a[`IDX_HI:`IDX_LO] == idx[`IDX_W-1:0])
            && (a[`OFF_HI:`OFF_LO] == off);
    endfunction

    assign setup     = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    // zero wait states: every access completes in its first access cycle
    assign pready    = 1'b1;

    always_comb
    begin
        d        = q;
        d.rdata  = `WORD_ZERO;
        d.slverr = 1'b0;
        if (setup)
        begin
            d.slverr = !(paddr == `ADDR_PINS);
            if (paddr == `ADDR_PINS && !pwrite)
                d.rdata[`NUM_MODULES-1:0] = module_output_pin;
            for (int i = 0; i < `NUM_MODULES; i++)
            begin
                if (hit(paddr, i, `OFF_MODE))
                begin
                    d.slverr = 1'b0;
                    if (!pwrite)
                        d.rdata[`BYTE_W-1:0] = q.mode[i];
                end
                if (hit(paddr, i, `OFF_LOW))
                begin
                    d.slverr = 1'b0;
                    if (!pwrite)
                        d.rdata[`BYTE_W-1:0] = cmp_low[i];
                end
                if (hit(paddr, i, `OFF_HIGH))
                begin
                    d.slverr = 1'b0;
                    if (!pwrite)
                        d.rdata[`BYTE_W-1:0] = cmp_high[i];
                end
            end
        end
        else if (psel && penable)
        begin
            // hold the answer for the whole access phase
            d.rdata  = q.rdata;
            d.slverr = q.slverr;
        end
        for (int i = 0; i < `NUM_MODULES; i++)
        begin
            if (wr_access && hit(paddr, i, `OFF_MODE))
                d.mode[i] = pwdata[`BYTE_W-1:0] & `MODE_MASK;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q.mode   <= {`NUM_MODULES{`MODE_RESET}};
            q.rdata  <= `WORD_ZERO;
            q.slverr <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    assign prdata  = q.rdata;
    assign pslverr = q.slverr;

    generate
        for (genvar g = 0; g < `NUM_MODULES; g++)
        begin : g_chan
            // per-module strobes keep each duty byte private
            assign wr_low[g]  = wr_access
                             && hit(paddr, g, `OFF_LOW); // see R4
            assign wr_high[g] = wr_access && hit(paddr, g, `OFF_HIGH);

            compare_channel u_chan
            (
                .clock         (clock),
                .rst_n         (rst_n),
                .counter_value (counter_value), // see R3
                .mode          (q.mode[g]),
                .wr_low        (wr_low[g]),
                .wr_high       (wr_high[g]),
                .wdata         (pwdata[`BYTE_W-1:0]),
                .pin           (module_output_pin[g]),
                .cmp_low       (cmp_low[g]),
                .cmp_high      (cmp_high[g])
            );
        end
    endgenerate

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    mode_write_a: assert property ( // see R2
        wr_access && hit(paddr, 0, `OFF_MODE)
        |=> q.mode[0] == ($past(pwdata[`BYTE_W-1:0]) & `MODE_MASK))
        else $error("mode register write not taken");

    bad_addr_a: assert property (
        setup && paddr[`OFF_HI:`OFF_LO] == `OFF_SPARE ##1 psel && penable
        |-> pslverr)
        else $error("unmapped address not answered with an error");

endmodule

/* File: tb/counter_array_compare_bench.sv */
`timescale 1ns/100ps
`include "counter_array_cfg.svh"

module counter_array_compare_bench
    import counter_array_pkg::*;
;
    logic                    clock;
    logic                    resetn;
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [`ADDR_W-1:0]      paddr;
    logic [`DATA_W-1:0]      pwdata;
    logic                    pready;
    logic [`DATA_W-1:0]      prdata;
    logic                    pslverr;
    logic [`CNT_W-1:0]       counter_value;
    logic [`NUM_MODULES-1:0] module_output_pin;
    logic [`NUM_MODULES-1:0] exp_pins;
    logic [`DATA_W-1:0]      rd;
    logic                    err;
    logic [`BYTE_W-1:0]      bad_modes [3];
    int                      errors;
    int                      cmp_count;

    counter_array_compare counter_array_compare_i (
        .clock             (clock),
        .resetn            (resetn),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .pready            (pready),
        .prdata            (prdata),
        .pslverr           (pslverr),
        .counter_value     (counter_value),
        .module_output_pin (module_output_pin)
    );

    always #5 clock = ~clock;

    task automatic end_of_test();
        if (errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [`DATA_W-1:0] got,
                       input logic [`DATA_W-1:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // outputs are read in the active region of an edge: pre-edge values
    task automatic apb(input logic w, input logic [`ADDR_W-1:0] a,
                       input logic [`DATA_W-1:0] d);
        int n;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge clock);
            if (pready === 1'b1)
                break;
        end
        if (n == 16)
        begin
            errors++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [`ADDR_W-1:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d});
        chk({31'h00000000, err}, 32'h00000000);
    endtask

    task automatic rdc(input logic [`ADDR_W-1:0] a,
                       input logic [`DATA_W-1:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
        chk({31'h00000000, err}, 32'h00000000);
    endtask

    // one cycle of v, then nxt; returns at the edge where pin reflects v
    task automatic step(input logic [15:0] v, input logic [15:0] nxt);
        @(posedge clock);
        counter_value <= v;
        @(posedge clock);
        counter_value <= nxt;
        @(posedge clock);
    endtask

    task automatic pins();
        chk({27'h0000000, module_output_pin}, {27'h0000000, exp_pins});
    endtask

    task automatic t_reset();
        rdc(8'h00, 32'h00000000);
        rdc(8'h80, 32'h00000000);
        pins();
    endtask

    task automatic t_unmapped();
        apb(1'b1, 8'h0c, 32'h000000aa);
        chk({31'h00000000, err}, 32'h00000001);
        apb(1'b0, 8'h0c, 32'h00000000);
        chk(rd, 32'h00000000);
        chk({31'h00000000, err}, 32'h00000001);
    endtask

    task automatic t_hso();
        wr(8'h04, 8'h34);
        wr(8'h08, 8'h12);
        foreach (bad_modes[i])
        begin
            wr(8'h00, bad_modes[i]);
            step(16'h1234, 16'h0000);
            pins();
        end
        wr(8'h00, 8'h0b);
        step(16'h1234, 16'h0000);
        exp_pins[0] = 1'b1;
        pins();
        step(16'h1233, 16'h0000);
        pins();
        wr(8'h04, 8'h35);
        rdc(8'h80, 32'h00000001);
        // match held four cycles across both steps: one toggle per cycle
        step(16'h1235, 16'h1235);
        exp_pins[0] = 1'b0;
        pins();
        step(16'h1235, 16'h0000);
        exp_pins[0] = 1'b1;
        pins();
        wr(8'h00, 8'h00);
    endtask

    task automatic t_pwm();
        wr(8'h14, 8'h80);
        wr(8'h18, 8'h20);
        wr(8'h24, 8'h40);
        wr(8'h28, 8'h60);
        wr(8'h10, 8'h0c);
        wr(8'h20, 8'h0c);
        step(16'h007f, 16'h0000);
        exp_pins[2:1] = 2'b10;
        pins();
        step(16'h0080, 16'h0000);
        exp_pins[2:1] = 2'b11;
        pins();
        step(16'h003f, 16'h0000);
        exp_pins[2:1] = 2'b00;
        pins();
        wr(8'h20, 8'h04);
        step(16'h0050, 16'h0000);
        pins();
    endtask

    task automatic t_reload();
        step(16'h00ff, 16'h0100);
        exp_pins[1] = 1'b1;
        pins();
        rdc(8'h14, 32'h00000020);
        rdc(8'h24, 32'h00000040);
        // 30 sits between the new low byte 20 and the old 80
        step(16'h0130, 16'h0000);
        exp_pins[1] = 1'b1;
        pins();
    endtask

    initial
    begin
        clock = 1'b0;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        counter_value = 16'h0000;
        exp_pins = 5'h00;
        bad_modes = '{8'h03, 8'h09, 8'h0a};
        errors = 0;
        cmp_count = 0;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        t_reset();
        t_unmapped();
        t_hso();
        t_pwm();
        t_reload();
        end_of_test();
    end
endmodule
